// >>> irda_endec.sv
// Dual infrared encoder/decoder sitting between two UARTs and their transceivers
`timescale 1ns/10ps
`default_nettype none

module irda_endec (
	// Clock and reset
	input  wire logic                                       clk,
	input  wire logic                                       rst,
	// Configuration held in the paired UART control registers
	input  wire irda_pkg::chan_cfg_t [irda_pkg::NUM_CH-1:0] cfg,
	// UART transmit bit stream, one bit per bit period
	input  wire logic                [irda_pkg::NUM_CH-1:0] uart_tx_bit,
	input  wire logic                [irda_pkg::NUM_CH-1:0] uart_tx_valid,
	output logic                     [irda_pkg::NUM_CH-1:0] uart_tx_ready,
	// UART receive line
	output logic                     [irda_pkg::NUM_CH-1:0] uart_rxd,
	// Transceiver pins
	output logic                     [irda_pkg::NUM_CH-1:0] ir_modulated_out,
	input  wire logic                [irda_pkg::NUM_CH-1:0] ir_modulated_in
);

	typedef struct packed {
		irda_pkg::chan_st_t [irda_pkg::NUM_CH-1:0] ch;
	} state_t;

	state_t                      st_q;
	state_t                      st_d;
	logic [irda_pkg::NUM_CH-1:0] fifo_bit;
	logic [irda_pkg::NUM_CH-1:0] fifo_valid;
	logic [irda_pkg::NUM_CH-1:0] fifo_pop;

	// Encoder asks for the next bit at a bit boundary, or on any tick while idle
	function automatic logic tx_pop(input irda_pkg::chan_st_t c, input logic avail);
		tx_pop = c.tick && avail && (!c.tx.active || c.tx.cnt == irda_pkg::BIT_LAST);
	endfunction : tx_pop

	// High phase of an encoded zero bit
	function automatic logic in_pulse(input irda_pkg::tx_st_t t);
		in_pulse = t.active && !t.bit_val && t.cnt >= irda_pkg::PULSE_FIRST
			&& t.cnt <= irda_pkg::PULSE_LAST;
	endfunction : in_pulse

	// Next state of one channel
	function automatic irda_pkg::chan_st_t step(input irda_pkg::chan_st_t c,
			input irda_pkg::chan_cfg_t k, input logic avail, input logic bit_in, input logic pin_in);
		irda_pkg::chan_st_t n;
		logic               edge_fall;
		logic [3:0]         rcnt;
		n         = c;
		edge_fall = c.prev && !c.sync2;
		rcnt      = c.rx.cnt + 1'b1;
		// Two-stage synchroniser, then a third stage for edge detection
		n.sync1 = pin_in;
		n.sync2 = c.sync1;
		n.prev  = c.sync2;
		// Baud tick every divisor clocks; a zero divisor halts the codec
		n.tick = 1'b0;
		if (k.baud_divisor == '0) begin
			n.div_cnt = '0;
		end else if (c.div_cnt >= k.baud_divisor - 1'b1) begin
			n.div_cnt = '0;
			n.tick    = 1'b1;
		end else begin
			n.div_cnt = c.div_cnt + 1'b1;
		end
		// Encoder: one bit per 16 ticks, next bit fetched at the boundary
		if (c.tick) begin
			if (tx_pop(c, avail)) begin
				n.tx.active  = 1'b1;
				n.tx.bit_val = bit_in;
				n.tx.cnt     = '0;
			end else if (c.tx.active && c.tx.cnt == irda_pkg::BIT_LAST) begin
				n.tx.active = 1'b0;
			end else if (c.tx.active) begin
				n.tx.cnt = c.tx.cnt + 1'b1;
			end
		end
		// Pin: pulses when enabled, plain level otherwise
		if (k.infrared_codec_enable) begin
			n.pin_out = in_pulse(n.tx);
		end else begin
			n.pin_out = n.tx.active ? n.tx.bit_val : 1'b1;
		end
		// Decoder is held idle while this channel transmits
		if (!k.infrared_codec_enable || c.tx.active) begin
			n.rx.mode       = irda_pkg::RX_IDLE;
			n.rx.window     = 1'b0;
			n.rx.pulse_seen = 1'b0;
			n.rx.cnt        = '0;
			n.rxd           = k.infrared_codec_enable ? 1'b1 : c.sync2;
		end else begin
			case (c.rx.mode)
				irda_pkg::RX_IDLE: begin
					if (edge_fall) begin
						n.rx.mode       = irda_pkg::RX_TRACK;
						n.rx.cnt        = '0;
						n.rx.pulse_seen = 1'b1;
						n.rx.window     = 1'b0;
					end
				end
				irda_pkg::RX_TRACK: begin
					if (edge_fall && c.rx.window) begin
						n.rx.cnt        = '0;
						n.rx.pulse_seen = 1'b1;
						n.rx.window     = 1'b0;
					end else if (c.tick) begin
						n.rx.cnt = rcnt;
						if (rcnt == irda_pkg::RX_DECIDE && c.rx.pulse_seen) begin
							n.rxd           = 1'b0;
							n.rx.pulse_seen = 1'b0;
						end else if (rcnt == irda_pkg::RX_DECIDE && c.rx.window) begin
							n.rxd       = 1'b1;
							n.rx.mode   = irda_pkg::RX_IDLE;
							n.rx.window = 1'b0;
						end
						if (rcnt == irda_pkg::RX_WIN_OPEN) begin
							n.rx.window = 1'b1;
						end
					end
				end
				default: begin
					n.rx.mode = irda_pkg::RX_IDLE;
				end
			endcase
		end
		step = n;
	endfunction : step

	// Two identical channels, each with its own transmit buffer
	for (genvar g = 0; g < irda_pkg::NUM_CH; g++) begin : g_ch
		bit_fifo #(
			.WIDTH (irda_pkg::FIFO_WIDTH),
			.DEPTH (irda_pkg::FIFO_DEPTH)
		) u_tx_fifo (
			.clk       (clk),
			.rst       (rst),
			.in_data   (uart_tx_bit[g]),
			.in_valid  (uart_tx_valid[g]),
			.in_ready  (uart_tx_ready[g]),
			.out_data  (fifo_bit[g]),
			.out_valid (fifo_valid[g]),
			.out_ready (fifo_pop[g])
		);
		assign fifo_pop[g]         = tx_pop(st_q.ch[g], fifo_valid[g]);
		assign ir_modulated_out[g] = st_q.ch[g].pin_out;
		assign uart_rxd[g]         = st_q.ch[g].rxd;
	end

	// Next state of all channels; no software registers live here
	always_comb begin
		st_d = st_q;
		for (int i = 0; i < irda_pkg::NUM_CH; i++) begin
			st_d.ch[i] = step(st_q.ch[i], cfg[i], fifo_valid[i], fifo_bit[i], ir_modulated_in[i]);
		end
	end

	// State register; reset loads both line outputs high
	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
			for (int i = 0; i < irda_pkg::NUM_CH; i++) begin
				st_q.ch[i].pin_out <= irda_pkg::TX_PIN_RESET;
				st_q.ch[i].rxd     <= irda_pkg::RXD_RESET;
			end
		end else begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// Checks per channel
	for (genvar g = 0; g < irda_pkg::NUM_CH; g++) begin : g_chk
		property p_one_bit_low;
			cfg[g].infrared_codec_enable && st_q.ch[g].tx.active && st_q.ch[g].tx.bit_val
				&& $stable(cfg[g].infrared_codec_enable) |-> !ir_modulated_out[g];
		endproperty
		a_one_bit_low: assert property (p_one_bit_low) else $error("one bit drove the pin high");

		property p_zero_pulse;
			!$past(rst) && cfg[g].infrared_codec_enable && $stable(cfg[g].infrared_codec_enable)
				&& ir_modulated_out[g]
				|-> st_q.ch[g].tx.active && !st_q.ch[g].tx.bit_val
				&& st_q.ch[g].tx.cnt >= 4'h7 && st_q.ch[g].tx.cnt <= 4'h9;
		endproperty
		a_zero_pulse: assert property (p_zero_pulse) else $error("pulse outside ticks 7 to 9");

		property p_idle_low;
			!$past(rst) && cfg[g].infrared_codec_enable && $past(cfg[g].infrared_codec_enable)
				&& !st_q.ch[g].tx.active |-> !ir_modulated_out[g];
		endproperty
		a_idle_low: assert property (p_idle_low) else $error("idle infrared pin not low");

		property p_tick_gap;
			st_q.ch[g].tick && cfg[g].baud_divisor > 16'h0002 && $stable(cfg[g].baud_divisor)
				|=> !st_q.ch[g].tick [*2];
		endproperty
		a_tick_gap: assert property (p_tick_gap) else $error("baud ticks too close");

		property p_half_duplex;
			st_q.ch[g].tx.active |=> st_q.ch[g].rx.mode == irda_pkg::RX_IDLE;
		endproperty
		a_half_duplex: assert property (p_half_duplex) else $error("receiver ran during transmit");

		property p_resync;
			cfg[g].infrared_codec_enable && !st_q.ch[g].tx.active && st_q.ch[g].prev && !st_q.ch[g].sync2
				&& (st_q.ch[g].rx.mode == irda_pkg::RX_IDLE || st_q.ch[g].rx.window)
				|=> st_q.ch[g].rx.cnt == 4'h0 && st_q.ch[g].rx.pulse_seen && !st_q.ch[g].rx.window;
		endproperty
		a_resync: assert property (p_resync) else $error("falling edge did not reset counter");

		property p_rxd_at_eight;
			cfg[g].infrared_codec_enable && $past(cfg[g].infrared_codec_enable) && !$past(st_q.ch[g].tx.active)
				&& $changed(uart_rxd[g]) |-> st_q.ch[g].rx.cnt == 4'h8;
		endproperty
		a_rxd_at_eight: assert property (p_rxd_at_eight) else $error("output changed off count 8");

		property p_miss_idle;
			cfg[g].infrared_codec_enable && !st_q.ch[g].tx.active && st_q.ch[g].rx.mode == irda_pkg::RX_TRACK
				&& st_q.ch[g].rx.window && !st_q.ch[g].rx.pulse_seen && st_q.ch[g].tick
				&& st_q.ch[g].rx.cnt == 4'h7 && !(st_q.ch[g].prev && !st_q.ch[g].sync2)
				|=> uart_rxd[g] && st_q.ch[g].rx.mode == irda_pkg::RX_IDLE;
		endproperty
		a_miss_idle: assert property (p_miss_idle) else $error("missed pulse did not go idle");

		property p_window_open;
			st_q.ch[g].rx.mode == irda_pkg::RX_TRACK && !st_q.ch[g].rx.window && $past(st_q.ch[g].rx.window) == 1'b0
				&& st_q.ch[g].rx.cnt == 4'hB && st_q.ch[g].tick && cfg[g].infrared_codec_enable
				&& !st_q.ch[g].tx.active |=> st_q.ch[g].rx.window;
		endproperty
		a_window_open: assert property (p_window_open) else $error("window did not open at 12");

		// Reset clears both synchroniser stages and they hold pin values only two clocks after it, so the depth check waits for them
		property p_sync_delay;
			!$past(rst) && !$past(rst, 2) |-> st_q.ch[g].sync2 == $past(ir_modulated_in[g], 2);
		endproperty
		a_sync_delay: assert property (p_sync_delay) else $error("receive pin not two flops deep");

		// A pulse seen before count 8 must give a zero bit to the UART
		property p_decide_zero;
			cfg[g].infrared_codec_enable && !st_q.ch[g].tx.active && st_q.ch[g].rx.mode == irda_pkg::RX_TRACK
				&& st_q.ch[g].rx.pulse_seen && st_q.ch[g].tick && st_q.ch[g].rx.cnt == 4'h7
				&& !(st_q.ch[g].prev && !st_q.ch[g].sync2) |=> !uart_rxd[g];
		endproperty
		a_decide_zero: assert property (p_decide_zero) else $error("pulse did not give a zero bit");

		// Codec off: the UART sees the synchronised pin level
		property p_raw_rx;
			!cfg[g].infrared_codec_enable |=> uart_rxd[g] == $past(st_q.ch[g].sync2);
		endproperty
		a_raw_rx: assert property (p_raw_rx) else $error("raw receive level not passed");

		// A fetched bit starts a fresh 16 tick frame with the buffered value
		property p_tx_load;
			fifo_pop[g] |=> st_q.ch[g].tx.active && st_q.ch[g].tx.cnt == 4'h0
				&& st_q.ch[g].tx.bit_val == $past(fifo_bit[g]);
		endproperty
		a_tx_load: assert property (p_tx_load) else $error("encoder did not load the bit");

		// Tracking counter advances by one per tick and wraps at 15
		property p_cnt_step;
			cfg[g].infrared_codec_enable && !st_q.ch[g].tx.active && st_q.ch[g].rx.mode == irda_pkg::RX_TRACK
				&& st_q.ch[g].tick && !(st_q.ch[g].prev && !st_q.ch[g].sync2)
				|=> st_q.ch[g].rx.cnt == $past(st_q.ch[g].rx.cnt) + 4'h1;
		endproperty
		a_cnt_step: assert property (p_cnt_step) else $error("receive counter did not step");

		// Divisor two gives a tick on every other clock
		property p_tick_two;
			st_q.ch[g].tick && cfg[g].baud_divisor == 16'h0002 |=> !st_q.ch[g].tick;
		endproperty
		a_tick_two: assert property (p_tick_two) else $error("tick spacing wrong at divisor 2");

		// Receive line stays idle while this channel sends
		property p_rxd_quiet_tx;
			cfg[g].infrared_codec_enable && $past(cfg[g].infrared_codec_enable) && $past(st_q.ch[g].tx.active)
				|-> uart_rxd[g];
		endproperty
		a_rxd_quiet_tx: assert property (p_rxd_quiet_tx) else $error("receive line moved during send");
	end

endmodule : irda_endec

`default_nettype wire

// >>> irda_pkg.sv
// Shared constants and types of the infrared encoder/decoder pair
package irda_pkg;

	// Channel count and buffer shape
	localparam int NUM_CH     = 2;
	localparam int FIFO_WIDTH = 1;
	localparam int FIFO_DEPTH = 16;

	// Baud divisor width
	localparam int DIV_W = 16;

	// Bit timing, in baud ticks
	localparam logic [3:0] BIT_LAST    = 4'hF;
	localparam logic [3:0] PULSE_FIRST = 4'h7;
	localparam logic [3:0] PULSE_LAST  = 4'h9;
	localparam logic [3:0] RX_DECIDE   = 4'h8;
	localparam logic [3:0] RX_WIN_OPEN = 4'hC;

	// Reset levels of the line outputs
	localparam logic TX_PIN_RESET = 1'b1;
	localparam logic RXD_RESET    = 1'b1;

	// Receiver tracking mode
	typedef enum logic {
		RX_IDLE,
		RX_TRACK
	} rx_mode_t;

	// Per channel configuration from the paired UART control registers
	typedef struct packed {
		logic             infrared_codec_enable;
		logic [DIV_W-1:0] baud_divisor;
	} chan_cfg_t;

	// Encoder state
	typedef struct packed {
		logic       active;
		logic       bit_val;
		logic [3:0] cnt;
	} tx_st_t;

	// Decoder state
	typedef struct packed {
		rx_mode_t   mode;
		logic [3:0] cnt;
		logic       pulse_seen;
		logic       window;
	} rx_st_t;

	// Whole state of one channel
	typedef struct packed {
		logic [DIV_W-1:0] div_cnt;
		logic             tick;
		logic             sync1;
		logic             sync2;
		logic             prev;
		tx_st_t           tx;
		rx_st_t           rx;
		logic             pin_out;
		logic             rxd;
	} chan_st_t;

endpackage : irda_pkg

// >>> bit_fifo.sv
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none

module bit_fifo #(
	parameter int WIDTH = irda_pkg::FIFO_WIDTH,
	parameter int DEPTH = irda_pkg::FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Filling side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Draining side
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [CW-1:0]               count;
		logic                        ready;
	} fifo_st_t;

	fifo_st_t q;
	fifo_st_t d;
	logic     push;
	logic     pop;

	// Ready is registered so the source never sees a combinational path
	assign in_ready  = q.ready;
	assign out_valid = (q.count != '0);
	assign out_data  = q.mem[q.rd];
	assign push      = in_valid && q.ready;
	assign pop       = out_valid && out_ready;

	// Pointer and occupancy update
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = in_data;
			d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : q.wr + 1'b1;
		end
		if (pop) begin
			d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : q.rd + 1'b1;
		end
		if (push && !pop) begin
			d.count = q.count + 1'b1;
		end else if (pop && !push) begin
			d.count = q.count - 1'b1;
		end
		d.ready = (d.count != CW'(DEPTH));
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			q       <= '0;
			q.ready <= 1'b1;
		end else begin
			q <= d;
		end
	end

endmodule : bit_fifo

`default_nettype wire

// >>> ir_xcvr_model.sv
// Behavioural infrared transceiver driving one codec receive pin
`timescale 1ns/10ps
`default_nettype none

module ir_xcvr_model (
	// Clock
	input  wire logic clk,
	// Codec receive pin, low during a pulse
	output logic      line
);
	int seed = 32'h774E;

	// Released line idles high, as the transceiver output does
	initial line = 1'b1;

	// One 16 tick frame per bit; a zero carries a 3 tick pulse after 7 ticks
	task automatic send(input logic [15:0] bits, input int n, input int d);
		int j;
		for (int k = 0; k < n; k++) begin
			j = bits[k] ? 0 : $random(seed) % 2; // Jitter of one tick either way
			for (int c = 0; c < 16 * d; c++) begin
				line <= !(!bits[k] && c >= (7 + j) * d && c < (10 + j) * d);
				@(posedge clk);
			end
		end
		line <= 1'b1;
	endtask : send
endmodule : ir_xcvr_model
`default_nettype wire

// >>> irda_endec_test.sv
// Self-checking bench of the dual infrared codec
`timescale 1ns/10ps
`default_nettype none

module irda_endec_test;
	localparam int D = 2;
	localparam int P = 16 * D;

	logic                      clk;
	logic                      rst;
	irda_pkg::chan_cfg_t [1:0] cfg;
	logic [1:0]                tx_bit;
	logic [1:0]                tx_valid;
	logic [1:0]                tx_ready;
	logic [1:0]                rxd;
	logic [1:0]                pin_out;
	wire logic [1:0]           pin_in;
	logic [15:0]               tx_bits;
	logic [15:0]               rx_bits;
	logic [7:0]                data;
	logic                      cap [0:599];
	int                        n_errors;
	int                        checks;
	int                        seed;

	irda_endec u_dut (
		.clk             (clk),
		.rst             (rst),
		.cfg             (cfg),
		.uart_tx_bit     (tx_bit),
		.uart_tx_valid   (tx_valid),
		.uart_tx_ready   (tx_ready),
		.uart_rxd        (rxd),
		.ir_modulated_out(pin_out),
		.ir_modulated_in (pin_in)
	);
	ir_xcvr_model u_xcvr0 (.clk(clk), .line(pin_in[0]));
	ir_xcvr_model u_xcvr1 (.clk(clk), .line(pin_in[1]));

	// 250 MHz clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Expected transmit pin level, i clocks into the first bit
	function automatic logic exp_pin(input logic [15:0] bits, input int i);
		int ph;
		ph = i % P;
		return !bits[i / P] && ph >= 7 * D && ph < 10 * D;
	endfunction : exp_pin

	// Single bit comparison
	task automatic chk(input string what, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected %s expected %b seen %b", what, exp, got);
		end
	endtask : chk

	// Verdict and end of run
	task automatic test_done;
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : test_done

	// Hang guard, a few times the expected run length
	initial begin
		repeat (5000) @(posedge clk);
		n_errors++;
		test_done();
	end

	// Main sequence
	initial begin
		int t0;
		seed = 32'h774E;
		n_errors = 0;
		checks = 0;
		rst = 1'b1;
		tx_bit = 2'h0;
		tx_valid = 2'h0;
		cfg[0] = '{infrared_codec_enable: 1'b1, baud_divisor: 16'h0000};
		cfg[1] = '{infrared_codec_enable: 1'b1, baud_divisor: 16'h0000};
		repeat (2) @(posedge clk);
		#1 chk("pin_out0", 1'b1, pin_out[0]);
		chk("rxd0", 1'b1, rxd[0]);
		chk("tx_ready0", 1'b1, tx_ready[0]);
		rst <= 1'b0;
		// Fill the buffer while ticks are stopped, start bit forced to zero
		tx_bits = 16'($random(seed));
		tx_bits[0] = 1'b0;
		for (int k = 0; k < 16; k++) begin
			tx_bit[0] <= tx_bits[k];
			tx_valid[0] <= 1'b1;
			@(posedge clk);
			while (tx_ready[0] !== 1'b1) @(posedge clk);
		end
		tx_valid[0] <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk("tx_ready0", 1'b0, tx_ready[0]);
		chk("pin_out0", 1'b0, pin_out[0]);
		data = 8'($random(seed));
		rx_bits = {4'h0, 1'b0, 2'b11, data, 1'b0};
		@(posedge clk);
		cfg[0].baud_divisor <= 16'(D);
		cfg[1].baud_divisor <= 16'(D);
		// Channel 0 sends while its own pin is pulsed; channel 1 receives
		fork
			for (int i = 0; i < 600; i++) begin
				@(posedge clk);
				#1 cap[i] = pin_out[0];
				if (i >= 40 && i < 400) chk("rxd0", 1'b1, rxd[0]);
				chk("pin_out1", 1'b0, pin_out[1]);
			end
			begin
				repeat (8) @(posedge clk);
				u_xcvr0.send(16'h0000, 8, D);
			end
			u_xcvr1.send(rx_bits, 12, D);
			for (int k = 0; k < 12; k++) begin
				repeat (k == 0 ? 24 * D : P) @(posedge clk);
				#1 chk("rxd1", rx_bits[k], rxd[1]);
			end
		join
		t0 = -1;
		for (int i = 0; i < 600; i++) begin
			if (t0 < 0 && cap[i] === 1'b1) t0 = i;
		end
		chk("pulse_found", 1'b1, 1'(t0 >= 7 * D));
		if (t0 >= 7 * D) begin
			for (int i = 0; i < 16 * P; i++) begin
				chk("pin_out0", exp_pin(tx_bits, i), cap[t0 - 7 * D + i]);
			end
		end
		chk("tx_ready0", 1'b1, tx_ready[0]);
		// Codec off on channel 1: raw levels pass both ways
		cfg[1].infrared_codec_enable <= 1'b0;
		cfg[1].baud_divisor <= 16'h0003;
		tx_bit[1] <= 1'b0;
		tx_valid[1] <= 1'b1;
		@(posedge clk);
		tx_valid[1] <= 1'b0;
		repeat (P / 2) @(posedge clk);
		#1 chk("pin_out1", 1'b0, pin_out[1]);
		repeat (2 * P) @(posedge clk);
		#1 chk("pin_out1", 1'b1, pin_out[1]);
		fork
			u_xcvr1.send(16'h0000, 1, D);
			begin
				// Low for every jitter choice of the model, after three flops
				repeat (19) @(posedge clk);
				#1 chk("rxd1", 1'b0, rxd[1]);
			end
		join
		repeat (5) @(posedge clk);
		#1 chk("rxd1", 1'b1, rxd[1]);
		test_done();
	end
endmodule : irda_endec_test
`default_nettype wire
